// [logic/icp_pkg.sv]
// Constants for the I2C coprocessor: register numbers, reset values,
// the state encoding of the bus slave and the timing counts.
// Assumes a 25 MHz system clock; the top module imports nothing.
`default_nettype none
package icp_pkg;
	// Bus address of the slave, seven bits.
	localparam logic [6:0] SLAVE_ADDR   = 7'h20;
	// Register numbers.
	localparam logic [7:0] REG_DIR_A    = 8'h30;
	localparam logic [7:0] REG_IN_A     = 8'h31;
	localparam logic [7:0] REG_OUT_A    = 8'h32;
	localparam logic [7:0] REG_DIR_B    = 8'h33;
	localparam logic [7:0] REG_IN_B     = 8'h34;
	localparam logic [7:0] REG_OUT_B    = 8'h35;
	localparam logic [4:0] REG_INBIT_A  = 5'h08; // 40h..47h, top bits.
	localparam logic [4:0] REG_INBIT_B  = 5'h09; // 48h..4Fh, top bits.
	localparam logic [4:0] REG_OBIT_A   = 5'h0a; // 50h..57h, top bits.
	localparam logic [4:0] REG_OBIT_B   = 5'h0b; // 58h..5Fh, top bits.
	localparam logic [7:0] REG_PWM_EN   = 8'h60;
	localparam logic [7:0] REG_PWM_PER  = 8'h61;
	localparam logic [7:0] REG_PWM_DUTY = 8'h62;
	localparam logic [7:0] REG_PWM_PRE  = 8'h63;
	localparam logic [7:0] REG_RTC_EN   = 8'h70;
	localparam logic [7:0] REG_SEC      = 8'h71;
	localparam logic [7:0] REG_MIN      = 8'h72;
	localparam logic [7:0] REG_HOUR     = 8'h73;
	localparam logic [7:0] REG_WDAY     = 8'h74;
	localparam logic [7:0] REG_MDAY     = 8'h75;
	localparam logic [7:0] REG_MONTH    = 8'h76;
	localparam logic [7:0] REG_YEAR     = 8'h77;
	localparam logic [7:0] REG_VER      = 8'h7f;
	// Version value; arbitrary.
	localparam logic [7:0] VER_VALUE    = 8'h01;
	// Reset values.
	localparam logic [7:0] DIR_RST      = 8'hff;
	localparam logic [7:0] OUT_RST      = 8'h00;
	localparam logic [7:0] EN_RST       = 8'h00;
	localparam logic [7:0] PER_RST      = 8'hff;
	localparam logic [7:0] DUTY_RST     = 8'h80;
	localparam logic [7:0] PRE_RST      = 8'h00;
	localparam logic [7:0] ZERO_RST     = 8'h00;
	localparam logic [7:0] ONE_RST      = 8'h01;
	// Calendar limits.
	localparam logic [7:0] SEC_MAX      = 8'h3b;
	localparam logic [7:0] HOUR_MAX     = 8'h17;
	localparam logic [7:0] WDAY_MAX     = 8'h07;
	localparam logic [7:0] MONTH_MAX    = 8'h0c;
	localparam logic [7:0] YEAR_MAX     = 8'h63;
	// Prescale divisors for codes 0, 1 and 2 or above.
	localparam logic [4:0] PRE_DIV1     = 5'h01;
	localparam logic [4:0] PRE_DIV4     = 5'h04;
	localparam logic [4:0] PRE_DIV16    = 5'h10;
	// Timing: clock period and one microsecond, in ns.
	localparam int CLK_NS     = 40;
	localparam int US_NS      = 1000;
	localparam int US_CYC     = US_NS / CLK_NS;
	// Microseconds in one second, the default of the top parameter.
	localparam int SEC_US_DEF = 1000000;
	// Bus slave states.
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0,
		ST_ADDR  = 4'h1,
		ST_AACK  = 4'h2,
		ST_REG   = 4'h3,
		ST_RACK  = 4'h4,
		ST_WDAT  = 4'h5,
		ST_WACK  = 4'h6,
		ST_RDAT  = 4'h7,
		ST_RDACK = 4'h8
	} icp_state_t;
endpackage : icp_pkg
`default_nettype wire

// [logic/icp_top.sv]
// I2C coprocessor: two 8-bit ports, a PWM output and a clock/calendar,
// reached as registers behind an I2C slave.
// Assumes SCL and SDA arrive from outside and are open drain.
//
// Behaviour
// - Slave at 20h; register number then value.
// - Writing 1 to 70h starts the clock.
// - Two 8-bit ports, direction 1 is input.
// - All port bits are inputs after reset.
// - Output writes do not reach input pins.
// - Output bits read back their driven level.
// - Inputs read as byte or single bit.
// - PWM enable register switches output on/off.
// - Prescale codes 0,1,2 divide by 1,4,16.
// - Period is (period+1) times divisor microseconds.
// - High for duty over period plus one.
// - Reset duty cycle is fifty percent.
// - Enable anytime; duty change keeps the period.
// - Clock keeps advancing while enabled.
// - Time registers writable even while running.
// - Seconds, minutes 0-59; hours 0-23.
// - Weekday counts 1 through 7.
// - Day 1-31, month 1-12.
// - Year 00-99, wraps to 00.
// - Read returns selected register's byte.
`timescale 1ns/1ns
`default_nettype none
module icp_top #(
	parameter int SEC_US = icp_pkg::SEC_US_DEF
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe,
	input  wire logic [7:0] port_a_i,
	output logic      [7:0] port_a_o,
	output logic      [7:0] port_a_oe,
	input  wire logic [7:0] port_b_i,
	output logic      [7:0] port_b_o,
	output logic      [7:0] port_b_oe,
	output logic            pwm_o
);

////////////////////////////////////////////////////////////////////////
// Input synchronisers.

	logic [1:0] scl_s_q;   // SCL sync chain.
	logic [1:0] sda_s_q;   // SDA sync chain.
	logic       scl_p_q;   // SCL one cycle later, for edges.
	logic       sda_p_q;   // SDA one cycle later, for edges.
	logic [7:0] pa_s1_q;   // Port A first stage.
	logic [7:0] pa_s2_q;   // Port A second stage.
	logic [7:0] pb_s1_q;   // Port B first stage.
	logic [7:0] pb_s2_q;   // Port B second stage.

	// Every pin passes two flops; edges look only at stage two.
	always_ff @(posedge clk) begin
		if (rst) begin
			scl_s_q <= 2'h3;
			sda_s_q <= 2'h3;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			pa_s1_q <= 8'h00;
			pa_s2_q <= 8'h00;
			pb_s1_q <= 8'h00;
			pb_s2_q <= 8'h00;
		end else begin
			scl_s_q <= {scl_s_q[0], scl_i};
			sda_s_q <= {sda_s_q[0], sda_i};
			scl_p_q <= scl_s_q[1];
			sda_p_q <= sda_s_q[1];
			pa_s1_q <= port_a_i;
			pa_s2_q <= pa_s1_q;
			pb_s1_q <= port_b_i;
			pb_s2_q <= pb_s1_q;
		end
	end

	logic scl_rise; // SCL went high.
	logic scl_fall; // SCL went low.
	logic bus_start; // SDA fell while SCL high.
	logic bus_stop;  // SDA rose while SCL high.
	assign scl_rise  = scl_s_q[1] & ~scl_p_q;
	assign scl_fall  = ~scl_s_q[1] & scl_p_q;
	assign bus_start = scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];
	assign bus_stop  = scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];

////////////////////////////////////////////////////////////////////////
// I2C slave.

	icp_pkg::icp_state_t st_q; // Slave state.
	logic [3:0] cnt_q;   // Bits seen in this byte.
	logic [7:0] sh_q;    // Receive shifter.
	logic [7:0] tx_q;    // Transmit shifter.
	logic [7:0] ptr_q;   // Selected register number.
	logic       ack_q;   // Master acknowledged the read byte.
	logic       oe_q;    // Pulling SDA low.
	logic       wr_q;    // One-cycle write strobe.
	logic [7:0] wdat_q;  // Byte being written.
	logic [7:0] rd_data; // Read mux output.

	// Bits are sampled on SCL rise and SDA changes after SCL fall,
	// so the line is stable for the whole high phase.
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q   <= icp_pkg::ST_IDLE;
			cnt_q  <= 4'h0;
			sh_q   <= 8'h00;
			tx_q   <= 8'h00;
			ptr_q  <= 8'h00;
			ack_q  <= 1'b0;
			oe_q   <= 1'b0;
			wr_q   <= 1'b0;
			wdat_q <= 8'h00;
		end else begin
			wr_q <= 1'b0;
			if (bus_start) begin
				// A repeated start keeps the register number.
				st_q  <= icp_pkg::ST_ADDR;
				cnt_q <= 4'h0;
				oe_q  <= 1'b0;
			end else if (bus_stop) begin
				st_q <= icp_pkg::ST_IDLE;
				oe_q <= 1'b0;
			end else if (scl_rise) begin
				case (st_q)
					icp_pkg::ST_ADDR, icp_pkg::ST_REG,
					icp_pkg::ST_WDAT: begin
						sh_q  <= {sh_q[6:0], sda_s_q[1]};
						cnt_q <= cnt_q + 4'h1;
					end
					icp_pkg::ST_RDAT: begin
						cnt_q <= cnt_q + 4'h1;
					end
					icp_pkg::ST_RDACK: begin
						ack_q <= ~sda_s_q[1];
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				case (st_q)
					icp_pkg::ST_ADDR: begin
						// Only our address is acknowledged.
						if (cnt_q == 4'h8 &&
						    sh_q[7:1] == icp_pkg::SLAVE_ADDR) begin
							st_q <= icp_pkg::ST_AACK;
							oe_q <= 1'b1;
						end else if (cnt_q == 4'h8) begin
							st_q <= icp_pkg::ST_IDLE;
						end
					end
					icp_pkg::ST_AACK: begin
						cnt_q <= 4'h0;
						if (sh_q[0]) begin
							// Read: first bit out now.
							st_q <= icp_pkg::ST_RDAT;
							tx_q <= rd_data;
							oe_q <= ~rd_data[7];
						end else begin
							st_q <= icp_pkg::ST_REG;
							oe_q <= 1'b0;
						end
					end
					icp_pkg::ST_REG: begin
						// Register number byte.
						if (cnt_q == 4'h8) begin
							ptr_q <= sh_q;
							st_q  <= icp_pkg::ST_RACK;
							oe_q  <= 1'b1;
						end
					end
					icp_pkg::ST_RACK, icp_pkg::ST_WACK: begin
						if (st_q == icp_pkg::ST_WACK) begin
							ptr_q <= ptr_q + 8'h01;
						end
						st_q  <= icp_pkg::ST_WDAT;
						cnt_q <= 4'h0;
						oe_q  <= 1'b0;
					end
					icp_pkg::ST_WDAT: begin
						// Value byte: write it and acknowledge.
						if (cnt_q == 4'h8) begin
							wr_q   <= 1'b1;
							wdat_q <= sh_q;
							st_q   <= icp_pkg::ST_WACK;
							oe_q   <= 1'b1;
						end
					end
					icp_pkg::ST_RDAT: begin
						if (cnt_q == 4'h8) begin
							// Release for the master's answer.
							st_q  <= icp_pkg::ST_RDACK;
							oe_q  <= 1'b0;
							ptr_q <= ptr_q + 8'h01;
						end else begin
							oe_q <= ~tx_q[6];
							tx_q <= {tx_q[6:0], 1'b0};
						end
					end
					icp_pkg::ST_RDACK: begin
						cnt_q <= 4'h0;
						if (ack_q) begin
							st_q <= icp_pkg::ST_RDAT;
							tx_q <= rd_data;
							oe_q <= ~rd_data[7];
						end else begin
							st_q <= icp_pkg::ST_IDLE;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Open drain: the pin is only ever pulled low.
	assign sda_o  = 1'b0;
	assign sda_oe = oe_q;

	ack_drive_a: assert property (@(posedge clk) disable iff (rst)
		(st_q == icp_pkg::ST_ADDR && scl_fall && cnt_q == 4'h8 &&
		 sh_q == {icp_pkg::SLAVE_ADDR, 1'b0}) |=> sda_oe)
		else $error("address not acknowledged");

////////////////////////////////////////////////////////////////////////
// Digital ports.

	logic [7:0] dir_a_q; // Port A direction, 1 is input.
	logic [7:0] dir_b_q; // Port B direction, 1 is input.
	logic [7:0] out_a_q; // Port A output latch.
	logic [7:0] out_b_q; // Port B output latch.
	logic [7:0] in_a;    // Port A readable level.
	logic [7:0] in_b;    // Port B readable level.

	// Byte and bit registers share one latch per port.
	always_ff @(posedge clk) begin
		if (rst) begin
			dir_a_q <= icp_pkg::DIR_RST;
			dir_b_q <= icp_pkg::DIR_RST;
			out_a_q <= icp_pkg::OUT_RST;
			out_b_q <= icp_pkg::OUT_RST;
		end else if (wr_q) begin
			if (ptr_q == icp_pkg::REG_DIR_A) begin
				dir_a_q <= wdat_q;
			end else if (ptr_q == icp_pkg::REG_DIR_B) begin
				dir_b_q <= wdat_q;
			end else if (ptr_q == icp_pkg::REG_OUT_A) begin
				out_a_q <= wdat_q;
			end else if (ptr_q == icp_pkg::REG_OUT_B) begin
				out_b_q <= wdat_q;
			end else if (ptr_q[7:3] == icp_pkg::REG_OBIT_A) begin
				// Only bit 0 counts; the host sends 0 or 1.
				out_a_q[ptr_q[2:0]] <= wdat_q[0];
			end else if (ptr_q[7:3] == icp_pkg::REG_OBIT_B) begin
				out_b_q[ptr_q[2:0]] <= wdat_q[0];
			end
		end
	end

	// The latch always stores, but input bits never drive.
	assign port_a_o  = out_a_q;
	assign port_b_o  = out_b_q;
	assign port_a_oe = ~dir_a_q;
	assign port_b_oe = ~dir_b_q;

	// Outputs read back what they drive, inputs the pin.
	assign in_a = (dir_a_q & pa_s2_q) | (~dir_a_q & out_a_q);
	assign in_b = (dir_b_q & pb_s2_q) | (~dir_b_q & out_b_q);

	port_reset_a: assert property (@(posedge clk)
		$fell(rst) |-> (port_a_oe == 8'h00 && port_b_oe == 8'h00))
		else $error("port drives after reset");

	out_read_a: assert property (@(posedge clk) disable iff (rst)
		(wr_q && ptr_q == icp_pkg::REG_OUT_A && dir_a_q == 8'h00)
		|=> in_a == $past(wdat_q))
		else $error("output not read back");

	in_pin_a: assert property (@(posedge clk) disable iff (rst)
		(dir_b_q[0] && pb_s2_q[0]) |-> in_b[0] && !port_b_oe[0])
		else $error("input bit not from pin");

////////////////////////////////////////////////////////////////////////
// Microsecond tick.

	logic [4:0] us_cnt_q; // Cycles within one microsecond.
	logic       us_tick;  // One-cycle pulse each microsecond.
	assign us_tick = (us_cnt_q == 5'(icp_pkg::US_CYC - 1));

	// Shared time base for the PWM and the clock.
	always_ff @(posedge clk) begin
		if (rst || us_tick) begin
			us_cnt_q <= 5'h00;
		end else begin
			us_cnt_q <= us_cnt_q + 5'h01;
		end
	end

////////////////////////////////////////////////////////////////////////
// PWM.

	logic [7:0] pwm_en_q;   // Enable register, bit 0 used.
	logic [7:0] per_q;      // Period value.
	logic [7:0] duty_q;     // Duty value.
	logic [7:0] pre_q;      // Prescale code.
	logic [4:0] pre_cnt_q;  // Microseconds within one step.
	logic [7:0] pcnt_q;     // Step within the period.
	logic [4:0] pre_div;    // Divisor for the code.
	logic       pwm_step;   // Advance the period counter.
	logic       pwm_q;      // Output flop.

	// Configuration writes; duty 128 of 256 gives half.
	always_ff @(posedge clk) begin
		if (rst) begin
			pwm_en_q <= icp_pkg::EN_RST;
			per_q    <= icp_pkg::PER_RST;
			duty_q   <= icp_pkg::DUTY_RST;
			pre_q    <= icp_pkg::PRE_RST;
		end else if (wr_q) begin
			if (ptr_q == icp_pkg::REG_PWM_EN) begin
				pwm_en_q <= wdat_q;
			end else if (ptr_q == icp_pkg::REG_PWM_PER) begin
				per_q <= wdat_q;
			end else if (ptr_q == icp_pkg::REG_PWM_DUTY) begin
				duty_q <= wdat_q;
			end else if (ptr_q == icp_pkg::REG_PWM_PRE) begin
				pre_q <= wdat_q;
			end
		end
	end

	// Codes above 2 are out of range and take the slowest rate.
	always_comb begin
		if (pre_q == 8'h00) begin
			pre_div = icp_pkg::PRE_DIV1;
		end else if (pre_q == 8'h01) begin
			pre_div = icp_pkg::PRE_DIV4;
		end else begin
			pre_div = icp_pkg::PRE_DIV16;
		end
	end

	assign pwm_step = us_tick && (pre_cnt_q >= pre_div - 5'h01);

	// Period of (per+1)*div us; duty never touches the counters.
	always_ff @(posedge clk) begin
		if (rst || !pwm_en_q[0]) begin
			pre_cnt_q <= 5'h00;
			pcnt_q    <= 8'h00;
		end else if (pwm_step) begin
			pre_cnt_q <= 5'h00;
			if (pcnt_q >= per_q) begin
				pcnt_q <= 8'h00;
			end else begin
				pcnt_q <= pcnt_q + 8'h01;
			end
		end else if (us_tick) begin
			pre_cnt_q <= pre_cnt_q + 5'h01;
		end
	end

	// High while the step is below duty; safe to toggle anytime.
	always_ff @(posedge clk) begin
		if (rst) begin
			pwm_q <= 1'b0;
		end else begin
			pwm_q <= pwm_en_q[0] && (pcnt_q < duty_q);
		end
	end
	assign pwm_o = pwm_q;

	pwm_off_a: assert property (@(posedge clk) disable iff (rst)
		!pwm_en_q[0] |=> !pwm_o)
		else $error("pwm high while disabled");

	pwm_wrap_a: assert property (@(posedge clk) disable iff (rst)
		(pwm_en_q[0] && pwm_step && pcnt_q == per_q) |=> pcnt_q == 8'h00)
		else $error("pwm period did not wrap");

	pwm_high_a: assert property (@(posedge clk) disable iff (rst)
		(pwm_en_q[0] && pcnt_q == 8'h00 && duty_q != 8'h00) |=> pwm_o)
		else $error("pwm low at start of period");

////////////////////////////////////////////////////////////////////////
// Clock and calendar.

	logic [7:0]  rtc_en_q; // Run register, bit 0 used.
	logic [19:0] sub_q;    // Microseconds within the second.
	logic        sec_tick; // One-cycle pulse each second.
	logic [7:0]  sec_q;    // Seconds.
	logic [7:0]  min_q;    // Minutes.
	logic [7:0]  hour_q;   // Hours, 24-hour only.
	logic [7:0]  wday_q;   // Weekday, 1 is Sunday.
	logic [7:0]  mday_q;   // Day of month.
	logic [7:0]  mon_q;    // Month.
	logic [7:0]  year_q;   // Two-digit year.
	logic [7:0]  dim;      // Days in the current month.

	assign sec_tick = rtc_en_q[0] && us_tick &&
	                  (sub_q == 20'(SEC_US - 1));

	// Second divider runs only while the clock is enabled.
	always_ff @(posedge clk) begin
		if (rst || sec_tick) begin
			sub_q <= 20'h00000;
		end else if (rtc_en_q[0] && us_tick) begin
			sub_q <= sub_q + 20'h00001;
		end
	end

	// Leap years are those divisible by four in the two-digit year.
	always_comb begin
		if (mon_q == 8'h02) begin
			dim = (year_q[1:0] == 2'h0) ? 8'h1d : 8'h1c;
		end else if (mon_q == 8'h04 || mon_q == 8'h06 ||
		             mon_q == 8'h09 || mon_q == 8'h0b) begin
			dim = 8'h1e;
		end else begin
			dim = 8'h1f;
		end
	end

	// Carry chain first; a host write to a unit wins that cycle.
	always_ff @(posedge clk) begin
		if (rst) begin
			rtc_en_q <= icp_pkg::EN_RST;
			sec_q    <= icp_pkg::ZERO_RST;
			min_q    <= icp_pkg::ZERO_RST;
			hour_q   <= icp_pkg::ZERO_RST;
			wday_q   <= icp_pkg::ONE_RST;
			mday_q   <= icp_pkg::ONE_RST;
			mon_q    <= icp_pkg::ONE_RST;
			year_q   <= icp_pkg::ZERO_RST;
		end else begin
			if (sec_tick) begin
				sec_q <= (sec_q >= icp_pkg::SEC_MAX) ? 8'h00
				         : sec_q + 8'h01;
				if (sec_q >= icp_pkg::SEC_MAX) begin
					min_q <= (min_q >= icp_pkg::SEC_MAX) ? 8'h00
					         : min_q + 8'h01;
				end
				if (sec_q >= icp_pkg::SEC_MAX &&
				    min_q >= icp_pkg::SEC_MAX) begin
					hour_q <= (hour_q >= icp_pkg::HOUR_MAX) ? 8'h00
					          : hour_q + 8'h01;
				end
				if (sec_q >= icp_pkg::SEC_MAX &&
				    min_q >= icp_pkg::SEC_MAX &&
				    hour_q >= icp_pkg::HOUR_MAX) begin
					wday_q <= (wday_q >= icp_pkg::WDAY_MAX) ? 8'h01
					          : wday_q + 8'h01;
					mday_q <= (mday_q >= dim) ? 8'h01
					          : mday_q + 8'h01;
					if (mday_q >= dim) begin
						mon_q <= (mon_q >= icp_pkg::MONTH_MAX) ? 8'h01
						         : mon_q + 8'h01;
						if (mon_q >= icp_pkg::MONTH_MAX) begin
							year_q <= (year_q >= icp_pkg::YEAR_MAX)
							          ? 8'h00 : year_q + 8'h01;
						end
					end
				end
			end
			if (wr_q) begin
				// Writable at any time, running or not.
				if (ptr_q == icp_pkg::REG_RTC_EN) begin
					rtc_en_q <= wdat_q;
				end else if (ptr_q == icp_pkg::REG_SEC) begin
					sec_q <= wdat_q;
				end else if (ptr_q == icp_pkg::REG_MIN) begin
					min_q <= wdat_q;
				end else if (ptr_q == icp_pkg::REG_HOUR) begin
					hour_q <= wdat_q;
				end else if (ptr_q == icp_pkg::REG_WDAY) begin
					wday_q <= wdat_q;
				end else if (ptr_q == icp_pkg::REG_MDAY) begin
					mday_q <= wdat_q;
				end else if (ptr_q == icp_pkg::REG_MONTH) begin
					mon_q <= wdat_q;
				end else if (ptr_q == icp_pkg::REG_YEAR) begin
					year_q <= wdat_q;
				end
			end
		end
	end

	rtc_start_a: assert property (@(posedge clk) disable iff (rst)
		(wr_q && ptr_q == icp_pkg::REG_RTC_EN && wdat_q == 8'h01)
		|=> rtc_en_q[0])
		else $error("clock did not start");

	day_wrap_a: assert property (@(posedge clk) disable iff (rst)
		(sec_tick && !wr_q && sec_q == 8'h3b && min_q == 8'h3b &&
		 hour_q == 8'h17) |=> (sec_q == 8'h00 && hour_q == 8'h00))
		else $error("day rollover wrong");

	week_wrap_a: assert property (@(posedge clk) disable iff (rst)
		(sec_tick && !wr_q && sec_q == 8'h3b && min_q == 8'h3b &&
		 hour_q == 8'h17 && wday_q == 8'h07) |=> wday_q == 8'h01)
		else $error("weekday did not wrap");

	year_wrap_a: assert property (@(posedge clk) disable iff (rst)
		(sec_tick && !wr_q && sec_q == 8'h3b && min_q == 8'h3b &&
		 hour_q == 8'h17 && mday_q == 8'h1f && mon_q == 8'h0c &&
		 year_q == 8'h63)
		|=> (year_q == 8'h00 && mon_q == 8'h01 && mday_q == 8'h01))
		else $error("year did not wrap");

////////////////////////////////////////////////////////////////////////
// Read mux.

	// Unmapped numbers read as zero.
	always_comb begin
		if (ptr_q == icp_pkg::REG_DIR_A) begin
			rd_data = dir_a_q;
		end else if (ptr_q == icp_pkg::REG_IN_A) begin
			rd_data = in_a;
		end else if (ptr_q == icp_pkg::REG_OUT_A) begin
			rd_data = out_a_q;
		end else if (ptr_q == icp_pkg::REG_DIR_B) begin
			rd_data = dir_b_q;
		end else if (ptr_q == icp_pkg::REG_IN_B) begin
			rd_data = in_b;
		end else if (ptr_q == icp_pkg::REG_OUT_B) begin
			rd_data = out_b_q;
		end else if (ptr_q[7:3] == icp_pkg::REG_INBIT_A) begin
			rd_data = {7'h00, in_a[ptr_q[2:0]]};
		end else if (ptr_q[7:3] == icp_pkg::REG_INBIT_B) begin
			rd_data = {7'h00, in_b[ptr_q[2:0]]};
		end else if (ptr_q[7:3] == icp_pkg::REG_OBIT_A) begin
			rd_data = {7'h00, out_a_q[ptr_q[2:0]]};
		end else if (ptr_q[7:3] == icp_pkg::REG_OBIT_B) begin
			rd_data = {7'h00, out_b_q[ptr_q[2:0]]};
		end else if (ptr_q == icp_pkg::REG_PWM_EN) begin
			rd_data = pwm_en_q;
		end else if (ptr_q == icp_pkg::REG_PWM_PER) begin
			rd_data = per_q;
		end else if (ptr_q == icp_pkg::REG_PWM_DUTY) begin
			rd_data = duty_q;
		end else if (ptr_q == icp_pkg::REG_PWM_PRE) begin
			rd_data = pre_q;
		end else if (ptr_q == icp_pkg::REG_RTC_EN) begin
			rd_data = rtc_en_q;
		end else if (ptr_q == icp_pkg::REG_SEC) begin
			rd_data = sec_q;
		end else if (ptr_q == icp_pkg::REG_MIN) begin
			rd_data = min_q;
		end else if (ptr_q == icp_pkg::REG_HOUR) begin
			rd_data = hour_q;
		end else if (ptr_q == icp_pkg::REG_WDAY) begin
			rd_data = wday_q;
		end else if (ptr_q == icp_pkg::REG_MDAY) begin
			rd_data = mday_q;
		end else if (ptr_q == icp_pkg::REG_MONTH) begin
			rd_data = mon_q;
		end else if (ptr_q == icp_pkg::REG_YEAR) begin
			rd_data = year_q;
		end else if (ptr_q == icp_pkg::REG_VER) begin
			rd_data = icp_pkg::VER_VALUE;
		end else begin
			rd_data = 8'h00;
		end
	end

endmodule : icp_top
`default_nettype wire

// [verif/icp_host.sv]
// I2C master model in the host's place.
// Assumes a pull-up on SDA; the slave only pulls it low.
`timescale 1ns/1ns
`default_nettype none
module icp_host (
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_m
);
	logic [7:0] rb [8];     // Bytes of the last read.
	logic       ok = 1'b1;  // Drops on any missing acknowledge.
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// Waits n falling edges, so changes stay off the sampling edge.
	task automatic w(input int n);
		repeat (n) @(negedge clk);
	endtask : w
	// One bit; data moves mid-low, never near an SCL edge.
	task automatic bx(input logic b, output logic s);
		w(4);
		sda_m = b;
		w(4);
		scl = 1'b1;
		w(8);
		s = sda;
		scl = 1'b0;
	endtask : bx
	// Start (st=1) or stop (st=0): SDA moves while SCL is high.
	task automatic cond(input logic st);
		w(4);
		sda_m = st;
		w(4);
		scl = 1'b1;
		w(8);
		sda_m = ~st;
		w(8);
		scl = ~st;
	endtask : cond
	// Byte out, MSB first, then the slave's acknowledge.
	task automatic wb(input logic [7:0] v);
		logic s;
		for (int j = 7; j >= 0; j--) bx(v[j], s);
		bx(1'b1, s);
		ok = ok & ~s;
	endtask : wb
	// Register number then value.
	task automatic wr(input logic [7:0] r, input logic [7:0] v);
		cond(1'b1);
		wb({icp_pkg::SLAVE_ADDR, 1'b0});
		wb(r);
		wb(v);
		cond(1'b0);
	endtask : wr
	// Select, repeated start, n bytes; the last gets a NACK.
	task automatic rd(input logic [7:0] r, input int n);
		logic s;
		cond(1'b1);
		wb({icp_pkg::SLAVE_ADDR, 1'b0});
		wb(r);
		cond(1'b1);
		wb({icp_pkg::SLAVE_ADDR, 1'b1});
		for (int i = 0; i < n; i++) begin
			for (int j = 7; j >= 0; j--) bx(1'b1, rb[i][j]);
			bx(i == n - 1, s);
		end
		cond(1'b0);
	endtask : rd
endmodule : icp_host
`default_nettype wire

// [verif/tb_i2c_coprocessor_io_pwm_rtc.sv]
// Bench for the coprocessor: ports, PWM and calendar.
// Assumes icp_host drives the bus; SEC_US is cut to 1000.
`timescale 1ns/1ns
`default_nettype none
module tb_i2c_coprocessor_io_pwm_rtc;
	logic       clk, rst, scl, sda_m, sda_o, sda_oe, pwm_o;
	logic [7:0] port_a_i, port_a_o, port_a_oe;
	logic [7:0] port_b_i, port_b_o, port_b_oe;
	logic [7:0] rnd = 8'h32, d, o;
	logic [2:0] k;
	logic       b;
	int         n_errors = 0, num_checks = 0, cnt, hi, per;
	wire logic  sda = sda_oe ? (sda_o & sda_m) : sda_m;
	localparam logic [7:0] TV [7] = '{8'h3b, 8'h3b, 8'h17, 8'h07,
		8'h1f, 8'h0c, 8'h63};
	localparam logic [7:0] EX [8] = '{8'h01, 8'h00, 8'h00, 8'h00,
		8'h01, 8'h01, 8'h01, 8'h00};
	icp_top #(.SEC_US(1000)) dut_u (.clk(clk), .rst(rst), .scl_i(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .port_a_i(port_a_i),
		.port_a_o(port_a_o), .port_a_oe(port_a_oe), .port_b_i(port_b_i),
		.port_b_o(port_b_o), .port_b_oe(port_b_oe), .pwm_o(pwm_o));
	icp_host m_u (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	// Clocks in n+1 PWM steps at prescale code c.
	function automatic int steps(input int c, input int n);
		return (n + 1) * (c == 0 ? 1 : c == 1 ? 4 : 16) * icp_pkg::US_CYC;
	endfunction : steps
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	// Counts falling edges until pwm_o reaches lvl, bounded.
	task automatic till(input logic lvl);
		cnt = 0;
		while (pwm_o !== lvl) begin
			@(negedge clk);
			cnt++;
			if (cnt > 4000) begin
				n_errors++;
				final_report;
			end
		end
	endtask : till
	// Skips two periods, then measures high time and period.
	task automatic meas;
		repeat (2) begin
			till(1'b0);
			till(1'b1);
		end
		till(1'b0);
		hi = cnt;
		till(1'b1);
		per = hi + cnt;
	endtask : meas
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (100000) @(posedge clk);
		n_errors++;
		final_report;
	end
	initial begin
		rst = 1'b1;
		port_a_i = 8'h00;
		port_b_i = 8'h00;
		repeat (6) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		m_u.w(8);
		chk({port_a_oe, port_b_oe}, 16'h0000);
		m_u.rd(icp_pkg::REG_DIR_A, 1);
		chk(m_u.rb[0], 8'hff);
		m_u.rd(icp_pkg::REG_PWM_PER, 2);
		chk({m_u.rb[0], m_u.rb[1]}, 16'hff80);
		$display("reset test done");
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			d = (i == 0) ? 8'h00 : rnd; // All outputs, a corner case.
			rnd = lfsr(rnd);
			o = rnd;
			rnd = lfsr(rnd);
			port_a_i = rnd;
			port_b_i = ~rnd;
			k = rnd[2:0];
			m_u.wr(icp_pkg::REG_DIR_A, d);
			m_u.wr(icp_pkg::REG_OUT_A, o);
			chk({port_a_oe, port_a_o}, {~d, o});
			m_u.rd(icp_pkg::REG_IN_A, 1);
			chk(m_u.rb[0], (port_a_i & d) | (o & ~d));
			m_u.wr({icp_pkg::REG_OBIT_A, k}, {7'h00, ~o[k]});
			chk(port_a_o, o ^ (8'h01 << k));
			m_u.wr(icp_pkg::REG_DIR_B, d);
			m_u.wr(icp_pkg::REG_OUT_B, o);
			m_u.rd({icp_pkg::REG_INBIT_B, k}, 1);
			chk({port_b_oe, port_b_o}, {~d, o});
			b = (port_b_i[k] & d[k]) | (o[k] & ~d[k]);
			chk(m_u.rb[0], {7'h00, b});
		end
		$display("port test done");
		m_u.wr(icp_pkg::REG_PWM_PER, 8'h03);
		m_u.wr(icp_pkg::REG_PWM_DUTY, 8'h01);
		m_u.wr(icp_pkg::REG_PWM_EN, 8'h01);
		for (int c = 0; c < 3; c++) begin
			m_u.wr(icp_pkg::REG_PWM_PRE, c[7:0]);
			meas;
			chk(hi, steps(c, 0));
			chk(per, steps(c, 3));
		end
		m_u.wr(icp_pkg::REG_PWM_DUTY, 8'h02);
		meas;
		chk(hi, steps(2, 1));
		chk(per, steps(2, 3));
		m_u.wr(icp_pkg::REG_PWM_EN, 8'h00);
		m_u.w(2);
		chk(pwm_o, 1'b0);
		$display("pwm test done");
		m_u.cond(1'b1);
		m_u.wb({icp_pkg::SLAVE_ADDR, 1'b0});
		m_u.wb(icp_pkg::REG_SEC);
		foreach (TV[i]) m_u.wb(TV[i]);
		m_u.cond(1'b0);
		m_u.wr(icp_pkg::REG_RTC_EN, 8'h01);
		cnt = 0;
		do begin
			m_u.rd(icp_pkg::REG_SEC, 1);
			cnt++;
		end while (m_u.rb[0] === 8'h3b && cnt < 60);
		if (m_u.rb[0] === 8'h3b) begin
			n_errors++;
			final_report;
		end
		m_u.rd(icp_pkg::REG_RTC_EN, 8);
		foreach (EX[i]) chk(m_u.rb[i], EX[i]);
		chk(m_u.ok, 1'b1);
		$display("calendar test done");
		final_report;
	end
endmodule : tb_i2c_coprocessor_io_pwm_rtc
`default_nettype wire
